//--- design/asc_regs.svh
`ifndef ASC_REGS_SVH
`define ASC_REGS_SVH

// ==========================================================================
// register offsets of one converter bank
`define ASC_REG_FACTORY      3'h0
`define ASC_REG_SYS_CTRL     3'h1
`define ASC_REG_FILTER_CTRL  3'h2
`define ASC_REG_DATA_FORMAT  3'h3
`define ASC_REG_LEFT_ATTEN   3'h4
`define ASC_REG_RIGHT_ATTEN  3'h5
`define ASC_REG_RATIO_HI     3'h6
`define ASC_REG_RATIO_LO     3'h7

// ==========================================================================
// field positions
`define ASC_SYS_POWER_BIT    7
`define ASC_SYS_TRACK_BIT    6
`define ASC_FILTER_MASK      8'h1F
`define ASC_FORMAT_MASK      8'hF7
`define ASC_LAT_LSB          0
`define ASC_DDN_BIT          2
`define ASC_DEM_LSB          3
`define ASC_IFMT_LSB         0
`define ASC_OFMT_LSB         4
`define ASC_OWL_LSB          6

// ==========================================================================
// reset values
`define ASC_RST_BYTE         8'h00
`define ASC_RST_BIT          1'b0
`define ASC_LAT_MAX_DEPTH    7'h40

// ==========================================================================
// access header byte
`define ASC_HDR_READ_BIT     7
`define ASC_HDR_BANKB_BIT    6
`define ASC_HDR_BANKA_BIT    5
`define ASC_HDR_ADDR_MSB     2
`define ASC_HDR_BITS         24

// ==========================================================================
// host controller registers and link timing
`define ASC_WB_CMD           8'h00
`define ASC_WB_STATUS        8'h04
`define ASC_CMD_ADDR_LSB     8
`define ASC_CMD_BANKA_BIT    11
`define ASC_CMD_BANKB_BIT    12
`define ASC_CMD_READ_BIT     13
`define ASC_CLK_PERIOD_NS    5
`define ASC_SCLK_HALF_NS     40
`define ASC_SCLK_HALF_CYC    ((`ASC_SCLK_HALF_NS + `ASC_CLK_PERIOD_NS - 1) \
                              / `ASC_CLK_PERIOD_NS)

`endif

//--- design/asc_pkg.sv
package asc_pkg;

  // ==========================================================================
  // host link sequencer
  typedef enum logic [4:0] {
    ASC_IDLE  = 5'b00001,
    ASC_SETUP = 5'b00010,
    ASC_LOW   = 5'b00100,
    ASC_HIGH  = 5'b01000,
    ASC_HOLD  = 5'b10000
  } asc_link_state_type;

  typedef logic [7:0] asc_byte_type;

endpackage

//--- design/asc_spi_if.sv
`timescale 1ns/1ps

interface asc_spi_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic miso_line;

  // released line reads low, as with a weak pull-down
  assign miso_line = miso_oe ? miso : 1'b0;

  modport dev (
    input  sclk,
    input  cs_n,
    input  mosi,
    output miso,
    output miso_oe
  );

  modport host (
    output sclk,
    output cs_n,
    output mosi,
    input  miso_line
  );
endinterface

//--- design/asc_sync.sv
`timescale 1ns/1ps

module asc_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  // first stage feeds only the second stage
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk_i) begin
    // reset to the pins' idle levels, so no false select or edge follows
    if (rst_i) begin
      meta_reg <= RST_VAL;
      sync_o   <= RST_VAL;
    end else begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end
endmodule

//--- design/asc_dev_end.sv
`timescale 1ns/1ps
`include "asc_regs.svh"

// Summary of operation
// - power bit low holds section powered down
// - power bit resets low, host writes one
// - latency field picks 64, 32, 16, 8
// - downsample bit zero runs decimation filter
// - downsample bit one skips filtering
// - de-emphasis field: off, 48k, 44.1k, 32k
// - input format: left-justified, i2s, reserved
// - top input format bit: right-justified widths
// - output format: lj, i2s, tdm, rj
// - word length: 24, 20, 18, 16
// - left attenuation in half-dB steps
// - right attenuation in half-dB steps
// - tracking copies left attenuation to right
// - ratio integer and fraction bit layout
// - high ratio read latches the low ratio register
// - two identical banks chosen by header
// - address increments after each data byte
// - ratio registers read-only, factory reads zero, others read-write
module asc_dev_end
  import asc_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  asc_spi_if.dev                spi,
  input  wire logic [1:0][15:0] ratio_i,
  output logic      [1:0]       section_power_on_o,
  output logic      [1:0]       atten_track_o,
  output logic      [1:0][1:0]  interp_latency_sel_o,
  output logic      [1:0][6:0]  interp_latency_depth_o,
  output logic      [1:0]       direct_downsample_sel_o,
  output logic      [1:0][1:0]  deemphasis_sel_o,
  output logic      [1:0][2:0]  input_format_sel_o,
  output logic      [1:0][1:0]  output_format_sel_o,
  output logic      [1:0][1:0]  output_word_length_sel_o,
  output logic      [1:0][7:0]  left_atten_steps_o,
  output logic      [1:0][7:0]  right_atten_steps_o
);

  // ==========================================================================
  // pin capture and edge detect
  logic [2:0]   pin_sync;
  logic         sclk_d_reg;
  logic [2:0]   bit_cnt_reg;
  logic [1:0]   byte_cnt_reg;
  logic [6:0]   shift_reg;
  asc_byte_type hdr_reg;
  logic [2:0]   addr_reg;
  asc_byte_type tx_reg;
  logic         miso_reg;
  logic         oe_reg;
  asc_byte_type bank_rd [2];

  asc_sync #(
    .WIDTH   (3),
    .RST_VAL (3'h2)
  ) u_pin_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i ({spi.sclk, spi.cs_n, spi.mosi}),
    .sync_o  (pin_sync)
  );

  wire          sclk_s     = pin_sync[2];
  wire          cs_n_s     = pin_sync[1];
  wire          mosi_s     = pin_sync[0];
  wire          sclk_rise  = sclk_s & ~sclk_d_reg & ~cs_n_s;
  wire          sclk_fall  = ~sclk_s & sclk_d_reg & ~cs_n_s;
  wire          byte_done  = sclk_rise & (bit_cnt_reg == 3'h7);
  wire [7:0]    rx_byte    = {shift_reg, mosi_s};
  wire          hdr_phase  = byte_cnt_reg == 2'h0;
  wire          data_phase = byte_cnt_reg == 2'h2;
  wire          is_read    = hdr_reg[`ASC_HDR_READ_BIT];
  wire [1:0]    bank_sel   = {hdr_reg[`ASC_HDR_BANKB_BIT],
                              hdr_reg[`ASC_HDR_BANKA_BIT]};
  // a read names one bank; bank a wins if both are set
  wire          rd_bank    = ~bank_sel[0];
  wire          wr_stb     = byte_done & data_phase & ~is_read;
  wire          load_tx    = byte_done & ~hdr_phase & is_read;
  wire [2:0]    rd_addr    = data_phase ? addr_reg + 3'h1 : addr_reg;
  wire [7:0]    rd_data    = bank_rd[rd_bank];

  assign spi.miso    = miso_reg;
  assign spi.miso_oe = oe_reg;

  // ==========================================================================
  // byte framing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclk_d_reg   <= 1'b0;
      bit_cnt_reg  <= 3'h0;
      byte_cnt_reg <= 2'h0;
      shift_reg    <= 7'h00;
      hdr_reg      <= `ASC_RST_BYTE;
      addr_reg     <= 3'h0;
    end else begin
      sclk_d_reg <= sclk_s;
      if (cs_n_s) begin
        bit_cnt_reg  <= 3'h0;
        byte_cnt_reg <= 2'h0;
      end else if (sclk_rise) begin
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        shift_reg   <= rx_byte[6:0];
        if (byte_done && !data_phase) begin
          byte_cnt_reg <= byte_cnt_reg + 2'h1;
        end
      end
      if (byte_done && hdr_phase) begin
        hdr_reg  <= rx_byte;
        addr_reg <= rx_byte[`ASC_HDR_ADDR_MSB:0];
      end else if (byte_done && data_phase) begin
        addr_reg <= addr_reg + 3'h1;
      end
    end
  end

  // ==========================================================================
  // read shifter: new bit after each falling clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_reg   <= `ASC_RST_BYTE;
      miso_reg <= 1'b0;
      oe_reg   <= 1'b0;
    end else begin
      oe_reg <= ~cs_n_s;
      if (cs_n_s) begin
        tx_reg <= `ASC_RST_BYTE;
      end else if (load_tx) begin
        tx_reg <= rd_data;
      end else if (sclk_fall) begin
        tx_reg <= {tx_reg[6:0], 1'b0};
      end
      if (sclk_fall) begin
        miso_reg <= tx_reg[7];
      end
    end
  end

  // ==========================================================================
  // one bank per section
  for (genvar b = 0; b < 2; b++) begin : g_bank
    logic         power_reg;
    logic         track_reg;
    asc_byte_type filter_reg;
    asc_byte_type format_reg;
    asc_byte_type left_reg;
    asc_byte_type right_reg;
    asc_byte_type ratio_lo_reg;
    asc_byte_type right_eff_reg;
    logic [6:0]   depth_reg;

    wire wr    = wr_stb & bank_sel[b];
    wire latch = load_tx & (rd_addr == `ASC_REG_RATIO_HI)
                 & (rd_bank == 1'(b));
    wire [7:0] ratio_hi = ratio_i[b][15:8];

    assign bank_rd[b] =
      (rd_addr == `ASC_REG_SYS_CTRL)    ? {power_reg, track_reg, 6'h00} :
      (rd_addr == `ASC_REG_FILTER_CTRL) ? filter_reg :
      (rd_addr == `ASC_REG_DATA_FORMAT) ? format_reg :
      (rd_addr == `ASC_REG_LEFT_ATTEN)  ? left_reg :
      (rd_addr == `ASC_REG_RIGHT_ATTEN) ? right_reg :
      (rd_addr == `ASC_REG_RATIO_HI)    ? ratio_hi :
      (rd_addr == `ASC_REG_RATIO_LO)    ? ratio_lo_reg : `ASC_RST_BYTE;

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        power_reg    <= `ASC_RST_BIT;
        track_reg    <= `ASC_RST_BIT;
        filter_reg   <= `ASC_RST_BYTE;
        format_reg   <= `ASC_RST_BYTE;
        left_reg     <= `ASC_RST_BYTE;
        right_reg    <= `ASC_RST_BYTE;
        ratio_lo_reg <= `ASC_RST_BYTE;
      end else begin
        if (wr && addr_reg == `ASC_REG_SYS_CTRL) begin
          power_reg <= rx_byte[`ASC_SYS_POWER_BIT];
          track_reg <= rx_byte[`ASC_SYS_TRACK_BIT];
        end
        if (wr && addr_reg == `ASC_REG_FILTER_CTRL) begin
          filter_reg <= rx_byte & `ASC_FILTER_MASK;
        end
        if (wr && addr_reg == `ASC_REG_DATA_FORMAT) begin
          format_reg <= rx_byte & `ASC_FORMAT_MASK;
        end
        if (wr && addr_reg == `ASC_REG_LEFT_ATTEN) begin
          left_reg <= rx_byte;
        end
        if (wr && addr_reg == `ASC_REG_RIGHT_ATTEN) begin
          right_reg <= rx_byte;
        end
        if (latch) begin
          ratio_lo_reg <= ratio_i[b][7:0];
        end
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        right_eff_reg <= `ASC_RST_BYTE;
        depth_reg     <= `ASC_LAT_MAX_DEPTH;
      end else begin
        right_eff_reg <= track_reg ? left_reg : right_reg;
        depth_reg <= `ASC_LAT_MAX_DEPTH >> filter_reg[`ASC_LAT_LSB +: 2];
      end
    end

    assign section_power_on_o[b]       = power_reg;
    assign atten_track_o[b]            = track_reg;
    assign interp_latency_sel_o[b]     = filter_reg[`ASC_LAT_LSB +: 2];
    assign interp_latency_depth_o[b]   = depth_reg;
    assign direct_downsample_sel_o[b]  = filter_reg[`ASC_DDN_BIT];
    assign deemphasis_sel_o[b]         = filter_reg[`ASC_DEM_LSB +: 2];
    assign input_format_sel_o[b]       = format_reg[`ASC_IFMT_LSB +: 3];
    assign output_format_sel_o[b]      = format_reg[`ASC_OFMT_LSB +: 2];
    assign output_word_length_sel_o[b] = format_reg[`ASC_OWL_LSB +: 2];
    assign left_atten_steps_o[b]       = left_reg;
    assign right_atten_steps_o[b]      = right_eff_reg;
  end

endmodule

//--- design/asc_host_end.sv
`timescale 1ns/1ps
`include "asc_regs.svh"

module asc_host_end
  import asc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  asc_spi_if.host          spi
);

  localparam logic [7:0] HALF_LAST = 8'(`ASC_SCLK_HALF_CYC - 1);

  // ==========================================================================
  // state
  asc_link_state_type state_reg;
  logic [7:0]         half_cnt_reg;
  logic [4:0]         bit_cnt_reg;
  logic [23:0]        tx_reg;
  logic [7:0]         rx_reg;
  logic [7:0]         rdata_reg;
  logic               done_reg;
  logic               sclk_reg;
  logic               cs_n_reg;
  logic               mosi_reg;
  logic               miso_s;

  asc_sync #(
    .WIDTH (1)
  ) u_miso_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (spi.miso_line),
    .sync_o  (miso_s)
  );

  wire       req       = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire       busy      = state_reg != ASC_IDLE;
  // a command needs both low lanes; ignored while busy
  wire       cmd_wr    = req & wb_we_i & (wb_adr_i == `ASC_WB_CMD)
                         & (wb_sel_i[1:0] == 2'b11) & ~busy;
  // bank bits: both allowed on write
  wire [7:0] hdr_byte  = {wb_dat_i[`ASC_CMD_READ_BIT],
                          wb_dat_i[`ASC_CMD_BANKB_BIT],
                          wb_dat_i[`ASC_CMD_BANKA_BIT], 2'b00,
                          wb_dat_i[`ASC_CMD_ADDR_LSB +: 3]};
  wire       half_end  = half_cnt_reg == HALF_LAST;
  wire       last_bit  = bit_cnt_reg == 5'(`ASC_HDR_BITS - 1);
  wire [31:0] status   = {16'h0000, rdata_reg, 6'h00, done_reg, busy};
  wire [31:0] rd_word  = (wb_adr_i == `ASC_WB_STATUS) ? status : 32'h0000_0000;

  assign spi.sclk = sclk_reg;
  assign spi.cs_n = cs_n_reg;
  assign spi.mosi = mosi_reg;

  // ==========================================================================
  // wishbone slave, one wait state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd_word : 32'h0000_0000;
    end
  end

  // ==========================================================================
  // link sequencer: mode 0, three bytes per access
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg    <= ASC_IDLE;
      half_cnt_reg <= 8'h00;
      bit_cnt_reg  <= 5'h00;
      tx_reg       <= 24'h00_0000;
      rx_reg       <= 8'h00;
      rdata_reg    <= 8'h00;
      done_reg     <= 1'b0;
      sclk_reg     <= 1'b0;
      cs_n_reg     <= 1'b1;
      mosi_reg     <= 1'b0;
    end else begin
      half_cnt_reg <= (state_reg == ASC_IDLE || half_end) ? 8'h00
                                                          : half_cnt_reg + 8'h01;
      // done set wins over the clear of a new command
      if (state_reg == ASC_HOLD && half_end) begin
        done_reg <= 1'b1;
      end else if (cmd_wr) begin
        done_reg <= 1'b0;
      end
      unique case (state_reg)
        ASC_IDLE: begin
          if (cmd_wr) begin
            cs_n_reg    <= 1'b0;
            mosi_reg    <= hdr_byte[7];
            tx_reg      <= {hdr_byte[6:0], 8'h00, wb_dat_i[7:0], 1'b0};
            bit_cnt_reg <= 5'h00;
            state_reg   <= ASC_SETUP;
          end
        end
        ASC_SETUP, ASC_LOW: begin
          if (half_end) begin
            sclk_reg  <= 1'b1;
            state_reg <= ASC_HIGH;
          end
        end
        ASC_HIGH: begin
          if (half_end) begin
            sclk_reg <= 1'b0;
            rx_reg   <= {rx_reg[6:0], miso_s};
            if (last_bit) begin
              state_reg <= ASC_HOLD;
            end else begin
              mosi_reg    <= tx_reg[23];
              tx_reg      <= {tx_reg[22:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg + 5'h01;
              state_reg   <= ASC_LOW;
            end
          end
        end
        ASC_HOLD: begin
          if (half_end) begin
            cs_n_reg  <= 1'b1;
            mosi_reg  <= 1'b0;
            rdata_reg <= rx_reg;
            state_reg <= ASC_IDLE;
          end
        end
      endcase
    end
  end

endmodule

//--- bench/asc_link_sva.sv
`timescale 1ns/1ps
module asc_link_sva (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic mosi,
  input  wire logic miso_oe
);
  logic       sclk_q;
  logic [4:0] rise_cnt;

  // ====================
  // link clock rises seen in the open frame
  always_ff @(posedge clk_i) begin
    sclk_q <= sclk;
    if (rst_i || cs_n) begin
      rise_cnt <= 5'h00;
    end else if (sclk && !sclk_q) begin
      rise_cnt <= rise_cnt + 5'h01;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // ====================
  // link framing
  chk_frame_bits: assert property (
    $rose(cs_n) |-> rise_cnt == 5'h18)
    else $error("frame closed without 24 link clock rises");
  chk_setup_gap: assert property (
    $fell(cs_n) |-> (!sclk)[*8] ##1 sclk)
    else $error("link clock setup gap wrong");
  chk_high_half: assert property (
    $rose(sclk) |-> sclk[*8] ##1 !sclk)
    else $error("link clock high phase not 8 cycles");
  chk_low_half: assert property (
    $fell(sclk) |-> (!sclk)[*8] ##1 (sclk || cs_n))
    else $error("link clock low phase not 8 cycles");
  chk_idle_clock: assert property (
    cs_n |-> !sclk)
    else $error("link clock moved outside a frame");
  // data only moves while the clock is low, so it is stable at sampling
  chk_data_stable: assert property (
    sclk |-> $stable(mosi))
    else $error("host data changed while link clock high");
  chk_oe_release: assert property (
    cs_n [*4] |-> !miso_oe)
    else $error("device drives data line while deselected");
  chk_oe_drive: assert property (
    (!cs_n) [*4] |-> miso_oe)
    else $error("device not driving data line in frame");
endmodule

//--- bench/asrc_section_control_regs_tb.sv
`timescale 1ns/1ps
module asrc_section_control_regs_tb;
  typedef struct packed {
    logic [1:0] bm;
    logic [2:0] a;
    logic [7:0] w;
    logic [7:0] rb;
  } asc_row_type;

  // ====================
  // signals
  logic             clk_i = 1'h0;
  logic             rst_i = 1'h1;
  logic             wb_cyc_i = 1'h0;
  logic             wb_stb_i = 1'h0;
  logic             wb_we_i = 1'h0;
  logic [7:0]       wb_adr_i = 8'h00;
  logic [3:0]       wb_sel_i = 4'hF;
  logic [31:0]      wb_dat_i = 32'h0000_0000;
  logic [31:0]      wb_dat_o;
  logic             wb_ack_o;
  logic [1:0][15:0] ratio_i = '0;
  logic [1:0]       section_power_on_o, atten_track_o;
  logic [1:0]       direct_downsample_sel_o;
  logic [1:0][1:0]  interp_latency_sel_o, deemphasis_sel_o;
  logic [1:0][1:0]  output_format_sel_o, output_word_length_sel_o;
  logic [1:0][6:0]  interp_latency_depth_o;
  logic [1:0][2:0]  input_format_sel_o;
  logic [1:0][7:0]  left_atten_steps_o, right_atten_steps_o;
  logic [7:0]       sh [2][8] = '{default: 8'h00};
  logic [23:0]      cap = 24'h00_0000;
  logic [23:0]      exp_frame = 24'h00_0000;
  logic             sck_q = 1'h0;
  logic             cs_q = 1'h1;
  int               n_fail = 0;
  int               check_count = 0;
  // bank mask, offset, written byte, byte read back
  asc_row_type      rows [17] = '{
    '{2'h1, 3'h2, 8'hFF, 8'h1F}, '{2'h2, 3'h2, 8'h09, 8'h09},
    '{2'h1, 3'h2, 8'h12, 8'h12}, '{2'h3, 3'h2, 8'hE5, 8'h05},
    '{2'h1, 3'h3, 8'h59, 8'h51}, '{2'h2, 3'h3, 8'hA4, 8'hA4},
    '{2'h1, 3'h3, 8'hFD, 8'hF5}, '{2'h2, 3'h3, 8'h06, 8'h06},
    '{2'h3, 3'h3, 8'h07, 8'h07}, '{2'h1, 3'h3, 8'h00, 8'h00},
    '{2'h1, 3'h4, 8'hA5, 8'hA5}, '{2'h1, 3'h5, 8'h3C, 8'h3C},
    '{2'h1, 3'h1, 8'h80, 8'h80}, '{2'h1, 3'h1, 8'hFF, 8'hC0},
    '{2'h1, 3'h1, 8'h40, 8'h40}, '{2'h2, 3'h2, 8'h00, 8'h00},
    '{2'h1, 3'h1, 8'h80, 8'h80}};

  always #2.5 clk_i = ~clk_i;

  // ====================
  // both ends joined by the link
  asc_spi_if u_asc_spi_if ();
  asc_host_end u_asc_host_end (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .spi(u_asc_spi_if.host));
  asc_dev_end u_asc_dev_end (.clk_i, .rst_i, .spi(u_asc_spi_if.dev),
    .ratio_i, .section_power_on_o, .atten_track_o, .interp_latency_sel_o,
    .interp_latency_depth_o, .direct_downsample_sel_o, .deemphasis_sel_o,
    .input_format_sel_o, .output_format_sel_o, .output_word_length_sel_o,
    .left_atten_steps_o, .right_atten_steps_o);
  asc_link_sva u_asc_link_sva (.clk_i, .rst_i, .sclk(u_asc_spi_if.sclk),
    .cs_n(u_asc_spi_if.cs_n), .mosi(u_asc_spi_if.mosi),
    .miso_oe(u_asc_spi_if.miso_oe));

  // ====================
  // checking helpers
  task automatic cmp(input logic [36:0] g, input logic [36:0] e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    cmp({29'h0, g}, {29'h0, e});
  endtask

  task automatic end_sim;
    $display("checks=%0d mismatches=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // expected settings of one bank, worked out from its shadow bytes
  function automatic logic [36:0] expv(input int b);
    logic [7:0] r1, r2, r3;
    r1 = sh[b][1];
    r2 = sh[b][2];
    r3 = sh[b][3];
    return {r1[7], r1[6], r2[1:0], 7'h40 >> r2[1:0], r2[2], r2[4:3],
      r3[2:0], r3[5:4], r3[7:6], sh[b][4], r1[6] ? sh[b][4] : sh[b][5]};
  endfunction

  function automatic logic [36:0] gotv(input int b);
    return {section_power_on_o[b], atten_track_o[b],
      interp_latency_sel_o[b], interp_latency_depth_o[b],
      direct_downsample_sel_o[b], deemphasis_sel_o[b],
      input_format_sel_o[b], output_format_sel_o[b],
      output_word_length_sel_o[b], left_atten_steps_o[b],
      right_atten_steps_o[b]};
  endfunction

  // ====================
  // bus cycles; ack is read before this edge's updates land
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'h1 && n < 50);
    if (n >= 50) begin
      n_fail++;
      end_sim();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    wb_we_i  <= 1'h0;
  endtask

  // poll status until the frame is done
  task automatic pl(output logic [7:0] q);
    logic [31:0] s;
    int          n;
    n = 0;
    do begin
      wb(1'h0, 8'h04, 32'h0000_0000, s);
      n++;
    end while (s[1] !== 1'h1 && n < 400);
    if (n >= 400) begin
      n_fail++;
      end_sim();
    end
    q = s[15:8];
  endtask

  // one link frame, then poll until done
  task automatic rg(input logic rd, input logic [1:0] bm,
                    input logic [2:0] a, input logic [7:0] d,
                    output logic [7:0] q);
    logic [31:0] s;
    exp_frame = {rd, bm, 2'h0, a, 8'h00, d};
    wb(1'h1, 8'h00, {18'h0, rd, bm, a, d}, s);
    pl(q);
  endtask

  // ====================
  // wire monitor: bits taken on link clock rise, frame checked at close
  always @(posedge clk_i) begin
    sck_q <= u_asc_spi_if.sclk;
    cs_q  <= u_asc_spi_if.cs_n;
    if (u_asc_spi_if.sclk && !sck_q) cap <= {cap[22:0], u_asc_spi_if.mosi};
    if (u_asc_spi_if.cs_n && !cs_q)
      cmp({13'h0, cap}, {13'h0, exp_frame});
  end

  // ====================
  // main sequence
  initial begin
    logic [7:0]  q;
    logic [31:0] s;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'h0;
    for (int b = 0; b < 2; b++) begin
      cmp(gotv(b), expv(b));
      for (int a = 2; a < 6; a++) begin
        rg(1'h1, 2'(b + 1), 3'(a), 8'h00, q);
        cmp8(q, 8'h00);
      end
    end
    $display("reset test done");
    foreach (rows[i]) begin
      rg(1'h0, rows[i].bm, rows[i].a, rows[i].w, q);
      for (int b = 0; b < 2; b++) begin
        if (rows[i].bm[b]) begin
          sh[b][rows[i].a] = rows[i].rb;
          rg(1'h1, 2'(b + 1), rows[i].a, 8'h00, q);
          cmp8(q, rows[i].rb);
        end
      end
      for (int b = 0; b < 2; b++) begin
        cmp(gotv(b), expv(b));
      end
      $display("row %0d done", i);
    end
    // ratio snapshot: a high read freezes the low byte
    ratio_i <= {16'h1357, 16'hABCD};
    rg(1'h1, 2'h1, 3'h6, 8'h00, q);
    cmp8(q, 8'hAB);
    ratio_i[0] <= 16'h2468;
    rg(1'h1, 2'h1, 3'h7, 8'h00, q);
    cmp8(q, 8'hCD);
    rg(1'h0, 2'h3, 3'h6, 8'hFF, q);
    rg(1'h1, 2'h1, 3'h6, 8'h00, q);
    cmp8(q, 8'h24);
    rg(1'h1, 2'h1, 3'h7, 8'h00, q);
    cmp8(q, 8'h68);
    rg(1'h1, 2'h2, 3'h6, 8'h00, q);
    cmp8(q, 8'h13);
    rg(1'h1, 2'h2, 3'h7, 8'h00, q);
    cmp8(q, 8'h57);
    cmp(gotv(0), expv(0));
    cmp(gotv(1), expv(1));
    wb(1'h0, 8'h08, 32'h0000_0000, s);
    cmp({5'h0, s}, 37'h0);
    $display("ratio test done");
    // refused commands: one while busy, one without both low lanes
    exp_frame = {1'h0, 2'h1, 2'h0, 3'h4, 8'h00, 8'h5A};
    wb(1'h1, 8'h00, 32'h0000_0C5A, s);
    wb(1'h1, 8'h00, 32'h0000_0DFF, s);
    wb(1'h0, 8'h04, 32'h0000_0000, s);
    cmp({35'h0, s[1:0]}, 37'h1);
    pl(q);
    sh[0][4] = 8'h5A;
    cmp(gotv(0), expv(0));
    wb_sel_i <= 4'h2;
    wb(1'h1, 8'h00, 32'h0000_0DFF, s);
    wb_sel_i <= 4'hF;
    wb(1'h0, 8'h04, 32'h0000_0000, s);
    cmp({35'h0, s[1:0]}, 37'h2);
    cmp(gotv(0), expv(0));
    $display("refusal test done");
    // mid-run reset: every field back to its reset value
    sh = '{default: 8'h00};
    rst_i <= 1'h1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    cmp(gotv(0), expv(0));
    cmp(gotv(1), expv(1));
    rg(1'h1, 2'h1, 3'h1, 8'h00, q);
    cmp8(q, 8'h00);
    $display("mid-run reset test done");
    end_sim();
  end
endmodule
